// [core/bus_cycle_controller.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - four address windows with own configs; anything else uses the default config.
// - each config sets address mode, data width, bus active bit and cycle length.
// - pin high at reset: single chip, default cleared except latch bit, type strapped.
// - single chip mode drives no bus pin and runs no external access.
// - bus built only when active bit set; bus type selects structure.
// - pin low at reset: default bus type strapped from port 0, later writable.
// - 64 KByte segments; offset on port 0 muxed, port 1 demuxed.
// - segment line count and select line count fixed at reset, read only.
// - segmentation disable decides whether code segment pointer is saved.
// - type 00 8b demux, 01 8b mux, 10 16b demux, 11 16b mux.
// - 8-bit mux keeps address high byte on port 0 high byte.
// - 16-bit mux word access leaves address bit 0 meaningless.
// - segment lines held steady on port 4 through the cycle.
// - mux cycle: latch strobe with address, strobe falls, address removed, command.
// - command phase: device drives write data, far side drives read data.
// - read end: data latched, strobe deasserted, far side releases bus.
// - write end: strobe deasserted, data held until next cycle starts.
// - demux: address steady on port 1, data on port 0, no latch.
// - demux: address first, command strobe after programmable delay.
// - after demux write, next cycle address goes straight onto port 1.
// - pin high at reset fetches internally, low fetches externally.
module bus_cycle_controller (
    input  wire logic                                        clk,
    input  wire logic                                        nrst,
    input  wire logic                                        ext_access_pin,
    input  wire logic                                        segmentation_disable_bit,
    input  wire bcc_pkg::win_range_s [bcc_pkg::NUM_WIN-1:0]  window_range_register,
    input  wire bcc_pkg::bus_cfg_s   [bcc_pkg::NUM_WIN-1:0]  bus_config_register,
    input  wire logic                                        dflt_cfg_wr,
    input  wire bcc_pkg::bus_cfg_s                           dflt_cfg_wdata,
    output var bcc_pkg::bus_cfg_s                            dflt_cfg,
    output logic [3:0]                                       reset_config_register,
    output logic                                             single_chip,
    output logic                                             fetch_external,
    output logic                                             save_code_segment_pointer,
    input  wire logic                                        req_valid,
    input  wire logic                                        req_write,
    input  wire logic                                        req_word,
    input  wire logic [bcc_pkg::ADDR_W-1:0]                  req_addr,
    input  wire logic [bcc_pkg::DATA_W-1:0]                  req_wdata,
    output logic                                             req_ready,
    output logic                                             rsp_valid,
    output logic                                             rsp_err,
    output logic [bcc_pkg::DATA_W-1:0]                       rsp_rdata,
    input  wire logic [15:0]                                 port0_in,
    output logic [15:0]                                      port0_out,
    output logic [15:0]                                      port0_oe,
    output logic [15:0]                                      port1_out,
    output logic [15:0]                                      port1_oe,
    output logic [7:0]                                       port4_out,
    output logic [7:0]                                       port4_oe,
    output logic                                             ale,
    output logic                                             read_strobe_n,
    output logic                                             write_low_strobe_n
);
    import bcc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        cyc_state_e  st;
        logic [3:0]  cnt;
        bus_cfg_s    cur;
        bus_cfg_s    dflt;
        logic [1:0]  seg_lines;
        logic [1:0]  sel_lines;
        logic        strap_done;
        logic        single_chip;
        logic        fetch_ext;
        logic        save_ptr;
        logic        ale;
        logic        rd_n;
        logic        wr_n;
        logic [15:0] p0_out;
        logic [15:0] p0_oe;
        logic [15:0] p1_out;
        logic [15:0] p1_oe;
        logic [7:0]  p4_out;
        logic [7:0]  p4_oe;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        ready;
        logic        rsp_valid;
        logic        rsp_err;
        logic [15:0] rdata;
    } state_s;

    localparam state_s STATE_RST = '{st: ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};

    state_s q;
    state_s d;

    window_if win ();

    window_decode u_decode (
        .w                     (win.decoder),
        .window_range_register (window_range_register),
        .bus_config_register   (bus_config_register)
    );

    assign win.addr = req_addr;
    assign win.dflt = q.dflt;

    // data phase drive of port 0 as {oe, out}
    function automatic logic [31:0] data_phase(input logic [1:0] bt, input logic wr,
                                               input logic [15:0] wd, input logic [23:0] a);
        logic [15:0] o;
        logic [15:0] e;
        o = 16'h0000;
        e = 16'h0000;
        if (wr) begin
            o = is_wide(bt) ? wd : {(is_mux(bt) ? a[15:8] : 8'h00), wd[7:0]};
            e = (is_wide(bt) || is_mux(bt)) ? 16'hFFFF : 16'h00FF;
        end else if (is_mux(bt) && !is_wide(bt)) begin
            o = {a[15:8], 8'h00};
            e = 16'hFF00;
        end
        return {e, o};
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        d.rsp_err   = 1'b0;
        d.save_ptr  = ~segmentation_disable_bit;
        if (!q.strap_done) begin
            // straps are caught on the first edge after release, never by the reset itself
            d.strap_done  = 1'b1;
            d.single_chip = ext_access_pin;
            d.fetch_ext   = ~ext_access_pin;
            d.dflt        = DFLT_CFG_RST;
            d.dflt.latch_ctl  = q.dflt.latch_ctl;
            d.dflt.bus_type   = port0_in[STRAP_BT_HI:STRAP_BT_LO];
            d.dflt.bus_active = ~ext_access_pin;
            d.seg_lines = port0_in[STRAP_SAL_HI:STRAP_SAL_LO];
            d.sel_lines = port0_in[STRAP_CS_HI:STRAP_CS_LO];
            d.ready  = 1'b1;
        end else if (dflt_cfg_wr) begin
            d.dflt = dflt_cfg_wdata;
        end

        unique case (q.st)
            ST_IDLE: begin
                if (q.ready && req_valid) begin
                    if (q.single_chip || !win.sel.bus_active) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_err   = 1'b1;
                    end else begin
                        d.ready = 1'b0;
                        d.cur   = win.sel;
                        d.addr  = req_addr;
                        d.wdata = req_wdata;
                        d.write = req_write;
                        d.st    = ST_ADDR;
                        d.cnt   = {3'h0, win.sel.latch_ctl};
                        d.p4_out = req_addr[23:16] & seg_mask(q.seg_lines);
                        d.p4_oe  = segmentation_disable_bit ? 8'h00 : seg_mask(q.seg_lines);
                        if (is_mux(win.sel.bus_type)) begin
                            d.ale    = 1'b1;
                            // word accesses on a 16-bit latch ignore bit 0
                            d.p0_out = {req_addr[15:1],
                                        req_addr[0] & ~(req_word & is_wide(win.sel.bus_type))};
                            d.p0_oe  = 16'hFFFF;
                        end else begin
                            // a new address replaces the old one at once after a write
                            d.p1_out = req_addr[15:0];
                            d.p1_oe  = 16'hFFFF;
                            d.p0_oe  = 16'h0000;
                        end
                    end
                end
            end
            ST_ADDR: begin
                if (is_mux(q.cur.bus_type)) begin
                    if (q.cnt != 4'h0) begin
                        d.cnt = q.cnt - 4'h1;
                    end else begin
                        d.ale = 1'b0;  // address stays one more cycle for the latch
                        d.st  = ST_HOLD;
                    end
                end else if (q.cur.cmd_delay) begin
                    d.st = ST_HOLD;
                end else begin
                    d.rd_n = q.write;
                    d.wr_n = ~q.write;
                    {d.p0_oe, d.p0_out} = data_phase(q.cur.bus_type, q.write, q.wdata, q.addr);
                    d.cnt = q.cur.waits;
                    d.st  = ST_CMD;
                end
            end
            ST_HOLD: begin
                d.rd_n = q.write;
                d.wr_n = ~q.write;
                {d.p0_oe, d.p0_out} = data_phase(q.cur.bus_type, q.write, q.wdata, q.addr);
                d.cnt = q.cur.waits;
                d.st  = ST_CMD;
            end
            ST_CMD: begin
                if (q.cnt != 4'h0) begin
                    d.cnt = q.cnt - 4'h1;
                end else begin
                    d.rd_n = 1'b1;
                    d.wr_n = 1'b1;
                    if (!q.write) begin
                        d.rdata = is_wide(q.cur.bus_type) ? port0_in : {8'h00, port0_in[7:0]};
                    end
                    d.rsp_valid = 1'b1;
                    d.ready     = 1'b1;
                    d.st        = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dflt_cfg                  = q.dflt;
    assign reset_config_register     = {q.seg_lines, q.sel_lines};
    assign single_chip               = q.single_chip;
    assign fetch_external            = q.fetch_ext;
    assign save_code_segment_pointer = q.save_ptr;
    assign req_ready                 = q.ready;
    assign rsp_valid                 = q.rsp_valid;
    assign rsp_err                   = q.rsp_err;
    assign rsp_rdata                 = q.rdata;
    assign port0_out                 = q.p0_out;
    assign port0_oe                  = q.p0_oe;
    assign port1_out                 = q.p1_out;
    assign port1_oe                  = q.p1_oe;
    assign port4_out                 = q.p4_out;
    assign port4_oe                  = q.p4_oe;
    assign ale                       = q.ale;
    assign read_strobe_n             = q.rd_n;
    assign write_low_strobe_n        = q.wr_n;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic [4:0] strobe_len;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_len <= 5'h00;
        end else if (!q.rd_n || !q.wr_n) begin
            strobe_len <= strobe_len + 5'h01;
        end else begin
            strobe_len <= 5'h00;
        end
    end

    sequence s_mux_start;
        $rose(q.ale);
    endsequence

    sequence s_latch_edge;
        $fell(q.ale) && (q.p0_oe != 16'h0000);
    endsequence

    AST_STROBES_EXCLUSIVE: assert property (!(!q.rd_n && !q.wr_n)) else $error("both strobes low");
    AST_SINGLE_CHIP_QUIET: assert property (q.single_chip |-> q.p0_oe == 16'h0000 && q.p1_oe == 16'h0000
        && q.p4_oe == 8'h00 && q.rd_n && q.wr_n && !q.ale) else $error("bus pin driven in single chip");
    AST_MUX_ORDER: assert property (s_mux_start ##[1:2] s_latch_edge |=> (!q.rd_n || !q.wr_n))
        else $error("mux cycle order wrong");
    AST_STROBE_LENGTH: assert property ($rose(q.rd_n) || $rose(q.wr_n) |-> $past(strobe_len) == {1'b0, q.cur.waits})
        else $error("command length differs from waits");
    AST_READ_RELEASE: assert property ($rose(q.rd_n) |-> q.rsp_valid && q.rdata == (is_wide(q.cur.bus_type)
        ? $past(port0_in) : {8'h00, $past(port0_in[7:0])})) else $error("read data not latched at strobe end");
    // a request taken right after the write starts the next cycle, which may move the data
    AST_WRITE_DATA_HELD: assert property ($rose(q.wr_n) && !(q.ready && req_valid)
        |=> $stable(q.p0_out) && $stable(q.p0_oe)) else $error("write data dropped early");
    AST_DEMUX_ADDR: assert property (q.st == ST_CMD && !is_mux(q.cur.bus_type) |-> q.p1_oe == 16'hFFFF
        && q.p1_out == q.addr[15:0]) else $error("demux address not on port 1");
    AST_DEMUX_DELAY: assert property (q.st == ST_ADDR && !is_mux(q.cur.bus_type) && q.cur.cmd_delay
        |=> q.rd_n && q.wr_n ##1 (!q.rd_n || !q.wr_n)) else $error("command delay not applied");
    AST_HIGH_BYTE_ADDR: assert property (q.st == ST_CMD && q.cur.bus_type == BT_8_MUX |-> q.p0_out[15:8]
        == q.addr[15:8] && q.p0_oe[15:8] == 8'hFF) else $error("high byte address lost");
    AST_SEG_STEADY: assert property (q.st != ST_IDLE |-> q.p4_out == (q.addr[23:16] & seg_mask(q.seg_lines)))
        else $error("segment lines moved");
    AST_STRAP: assert property ($rose(q.strap_done) |-> q.single_chip == $past(ext_access_pin)
        && q.fetch_ext == !$past(ext_access_pin) && q.dflt.bus_active == !$past(ext_access_pin))
        else $error("reset strap not taken");
    AST_INACTIVE_REFUSED: assert property (q.st == ST_IDLE && q.ready && req_valid && !win.sel.bus_active
        |=> q.rsp_err && q.st == ST_IDLE) else $error("inactive config ran a cycle");
    // the flag still shows its reset value on the strap edge, so only check once straps are in
    AST_SAVE_PTR: assert property (q.strap_done |=> q.save_ptr == !$past(segmentation_disable_bit))
        else $error("segment pointer save flag wrong");

endmodule // bus_cycle_controller
`default_nettype wire

// [core/ebc_pkg.sv]
package bcc_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 16;
    localparam int NUM_WIN = 4;

    // ------------------------------------------------------------------
    // bus type field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] BT_8_DEMUX  = 2'h0;
    localparam logic [1:0] BT_8_MUX    = 2'h1;
    localparam logic [1:0] BT_16_DEMUX = 2'h2;
    localparam logic [1:0] BT_16_MUX   = 2'h3;

    // ------------------------------------------------------------------
    // segment line count field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SAL_FOUR  = 2'h0;
    localparam logic [1:0] SAL_NONE  = 2'h1;
    localparam logic [1:0] SAL_EIGHT = 2'h2;
    localparam logic [1:0] SAL_TWO   = 2'h3;

    // ------------------------------------------------------------------
    // reset-time port 0 strap positions
    // ------------------------------------------------------------------
    localparam int STRAP_BT_HI  = 7;
    localparam int STRAP_BT_LO  = 6;
    localparam int STRAP_CS_HI  = 10;
    localparam int STRAP_CS_LO  = 9;
    localparam int STRAP_SAL_HI = 12;
    localparam int STRAP_SAL_LO = 11;

    // ------------------------------------------------------------------
    // configuration layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] waits;
        logic       cmd_delay;
        logic       latch_ctl;
        logic       bus_active;
        logic [1:0] bus_type;
    } bus_cfg_s;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0]  size;
    } win_range_s;

    localparam bus_cfg_s DFLT_CFG_RST  = '0;
    localparam logic     LATCH_CTL_RST = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_CMD  = 4'b1000
    } cyc_state_e;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_mux(input logic [1:0] bt);
        return bt[0];
    endfunction

    function automatic logic is_wide(input logic [1:0] bt);
        return bt[1];
    endfunction

    function automatic logic [7:0] seg_mask(input logic [1:0] sal);
        unique case (sal)
            SAL_TWO:   return 8'h03;
            SAL_EIGHT: return 8'hFF;
            SAL_NONE:  return 8'h00;
            SAL_FOUR:  return 8'h0F;
        endcase
    endfunction

endpackage

// [core/window_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface window_if;
    logic [23:0]      addr;
    bcc_pkg::bus_cfg_s dflt;
    bcc_pkg::bus_cfg_s sel;
    logic             hit;

    modport requester (output addr, output dflt, input sel, input hit);
    modport decoder   (input addr, input dflt, output sel, output hit);
endinterface
`default_nettype wire

// [core/window_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module window_decode (
    window_if.decoder                                w,
    input  wire bcc_pkg::win_range_s [bcc_pkg::NUM_WIN-1:0] window_range_register,
    input  wire bcc_pkg::bus_cfg_s   [bcc_pkg::NUM_WIN-1:0] bus_config_register
);
    import bcc_pkg::*;

    // a window covers 4 KByte shifted left by its size code
    function automatic logic win_hit(input win_range_s r, input logic [23:0] a);
        logic [11:0] m;
        m = ~(12'hFFF << r.size);
        return ((a[23:12] ^ r.base) & ~m) == 12'h000;
    endfunction

    // lowest window wins where windows overlap
    always_comb begin
        w.sel = w.dflt;
        w.hit = 1'b0;
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (win_hit(window_range_register[i], w.addr)) begin
                w.sel = bus_config_register[i];
                w.hit = 1'b1;
            end
        end
    end
endmodule // window_decode
`default_nettype wire

// [tb/ext_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input  wire logic        clk,
    input  wire logic        mux,
    input  wire logic        ale,
    input  wire logic [15:0] port0_out,
    input  wire logic [15:0] port1_out,
    input  wire logic [7:0]  port4_out,
    input  wire logic [7:0]  port4_oe,
    input  wire logic        read_strobe_n,
    input  wire logic        write_low_strobe_n,
    input  wire logic        strap_en,
    input  wire logic [15:0] strap,
    output var logic [15:0]  port0_in
);
    logic [15:0] mem [logic [23:0]];
    logic [15:0] lat_q;
    logic [15:0] last_q;
    logic [23:0] key;
    assign key = {port4_out & port4_oe, mux ? lat_q : port1_out};
    always @(negedge ale) lat_q <= port0_out;
    always @(posedge write_low_strobe_n) mem[key] = port0_out;
    always @(posedge clk) last_q <= port0_in;
    // a released bus toggles so that a stale level can never pass for data
    always @* begin
        if (strap_en)
            port0_in = strap;
        else if (!read_strobe_n)
            port0_in = mem.exists(key) ? mem[key] : ~key[15:0];
        else
            port0_in = ~last_q;
    end
endmodule // ext_mem_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module tb;
    import bcc_pkg::*;
    logic clk = 0, nrst = 0, ext_access_pin = 0, segmentation_disable_bit = 0, dflt_cfg_wr = 0;
    logic req_valid = 0, req_write = 0, req_word = 1, mux = 0, strap_en = 1;
    logic [23:0] req_addr = '0;
    logic [15:0] req_wdata = '0, strap = '0, port0_in, port0_out, port0_oe, port1_out, port1_oe, rsp_rdata;
    logic [7:0] port4_out, port4_oe, mask;
    logic [3:0] rcfg;
    logic single_chip, fetch_external, save_ptr, req_ready, rsp_valid, rsp_err, ale, rd_n, wr_n;
    logic [15:0] expect_fifo [$];
    bus_cfg_s dflt_cfg_wdata = '0, dflt_cfg;
    win_range_s [NUM_WIN-1:0] wr = '{'{12'hF03, 4'h0}, '{12'hF02, 4'h0}, '{12'hF01, 4'h0}, '{12'h010, 4'h0}};
    bus_cfg_s [NUM_WIN-1:0] bc;
    logic [7:0] mtab [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
    logic [31:0] seed = 63850;
    int err_count = 0, cmp_count = 0;
    always #12.5 clk = ~clk;
    bus_cycle_controller i_bus_cycle_controller (.clk, .nrst, .ext_access_pin, .segmentation_disable_bit,
        .window_range_register(wr), .bus_config_register(bc), .dflt_cfg_wr, .dflt_cfg_wdata, .dflt_cfg,
        .reset_config_register(rcfg), .single_chip, .fetch_external, .save_code_segment_pointer(save_ptr),
        .req_valid, .req_write, .req_word, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_err,
        .rsp_rdata, .port0_in, .port0_out, .port0_oe, .port1_out, .port1_oe, .port4_out, .port4_oe, .ale,
        .read_strobe_n(rd_n), .write_low_strobe_n(wr_n));
    ext_mem_model i_ext_mem_model (.clk, .mux, .ale, .port0_out, .port1_out, .port4_out, .port4_oe,
        .read_strobe_n(rd_n), .write_low_strobe_n(wr_n), .strap_en, .strap, .port0_in);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic pin_high);
        @(posedge clk);
        nrst <= 1'b0;
        strap_en <= 1'b1;
        ext_access_pin <= pin_high;
        strap <= 16'(xs());
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        strap_en <= 1'b0;
        mask = mtab[strap[12:11]];
    endtask
    task automatic set_dflt(input bus_cfg_s c);
        @(posedge clk);
        dflt_cfg_wr <= 1'b1;
        dflt_cfg_wdata <= c;
        @(posedge clk);
        dflt_cfg_wr <= 1'b0;
    endtask
    // one request; lat counts edges from the take edge to the answer
    task automatic xfer(input logic w, input logic [23:0] a, input logic [15:0] d, input int lat,
                        input logic [1:0] bt, input logic err);
        int n;
        logic [15:0] pa;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        mux <= bt[0];
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        pa = (bt[1] && req_word) ? {a[15:1], 1'b0} : a[15:0];
        do begin
            @(negedge clk);
            n++;
            if (n == 1 && !err) begin
                `CHK("port4", a[23:16] & (segmentation_disable_bit ? 8'h00 : mask), port4_out & port4_oe);
                `CHK("strobes", 2'b11, {rd_n, wr_n});
                `CHK("ale", bt[0], ale);
                if (bt[0])
                    `CHK("p0 addr", pa, port0_out);
                else
                    `CHK("p1 addr", a[15:0], port1_out);
            end
        end while (rsp_valid !== 1'b1 && n < 40);
        `CHK("latency", lat, n);
        `CHK("rsp err", err, rsp_err);
        if (w && !err)
            `CHK("write hold", d[7:0], port0_out[7:0]);
        if (w && !err)
            expect_fifo.push_back(bt[1] ? d : {8'h00, d[7:0]});
        if (!w && !err)
            `CHK("rdata", expect_fifo.pop_front(), rsp_rdata);
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        bus_cfg_s c;
        logic [31:0] r;
        logic [23:0] a;
        logic [15:0] d;
        int lat;
        bc = '{9'(xs()), 9'(xs()), '{4'h1, 1'b0, 1'b1, 1'b1, BT_16_MUX}, '0};
        do_reset(1'b0);
        `CHK("strap type", strap[7:6], dflt_cfg.bus_type);
        `CHK("rcfg", {strap[12:11], strap[10:9]}, rcfg);
        `CHK("fetch ext", 1'b1, fetch_external);
        `CHK("single", 1'b0, single_chip);
        for (int t = 0; t < 8; t++) begin
            r = xs();
            c = '{{2'b00, r[1:0]}, r[2], r[3], 1'b1, 2'(t)};
            @(posedge clk);
            segmentation_disable_bit <= t[2];
            req_word <= r[23];
            set_dflt(c);
            `CHK("ptr save", !t[2], save_ptr);
            a = {4'h2, r[22:3]};
            d = 16'(xs());
            lat = c.bus_type[0] ? 4 + c.latch_ctl + c.waits : 3 + c.cmd_delay + c.waits;
            xfer(1'b1, a, d, lat, c.bus_type, 1'b0);
            xfer(1'b0, a, d, lat, c.bus_type, 1'b0);
        end
        xfer(1'b0, 24'h010020, 16'h0, 1, 2'h0, 1'b1);
        xfer(1'b1, 24'hF01046, 16'h5AC3, 6, BT_16_MUX, 1'b0);
        xfer(1'b0, 24'hF01046, 16'h5AC3, 6, BT_16_MUX, 1'b0);
        set_dflt('{4'h0, 1'b0, 1'b0, 1'b0, BT_16_DEMUX});
        xfer(1'b0, 24'h200000, 16'h0, 1, 2'h0, 1'b1);
        do_reset(1'b1);
        `CHK("single", 1'b1, single_chip);
        `CHK("dflt sc", {7'h00, strap[7:6]}, dflt_cfg);
        `CHK("fetch int", 1'b0, fetch_external);
        set_dflt('{4'h0, 1'b0, 1'b0, 1'b1, BT_16_DEMUX});
        xfer(1'b1, 24'h200000, 16'h0, 1, 2'h0, 1'b1);
        `CHK("no pins", 1'b0, |{port0_oe, port1_oe, port4_oe, ale});
        final_report();
    end
    initial begin
        #(20000 * 25);
        err_count++;
        final_report();
    end
endmodule // tb
`default_nettype wire
